/* File: src/eeprom_engine_pkg.sv */
package eeprom_engine_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] OFS_COMMAND  = 12'h4A0;
  localparam logic [11:0] OFS_RDDATA   = 12'h4A4;
  localparam logic [11:0] OFS_STATUS   = 12'h4A8;
  localparam logic [11:0] OFS_INT_STAT = 12'h4D0;
  localparam logic [11:0] OFS_INT_MASK = 12'h4D4;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam logic [31:0] CMD_RESET   = 32'h5000_0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  localparam int          ACK_LSB     = 5;
  localparam int          DONE_BIT    = 0;
  localparam int          EV_DONE     = 0;
  localparam int          EV_NACK     = 1;
  localparam int          ACK_DEV     = 2;
  localparam int          ACK_MEM     = 1;
  localparam int          ACK_SECOND  = 0;
  localparam logic [1:0]  LAST_SEQ    = 2'h3;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int QUARTER_NS    = 2500;
  localparam int QUARTER_CYC   = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic       unused;
    logic [6:0] devAddr;
    logic [7:0] memAddr;
    logic [7:0] wrData;
    logic [5:0] rsvd;
    logic       rdLen4;
    logic       isRead;
  } command_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_TX    = 3'b010,
    ST_RX    = 3'b011,
    ST_STOP  = 3'b100
  } eng_state_t;

  typedef enum logic [2:0] {
    STG_DEVW = 3'b000,
    STG_MEM  = 3'b001,
    STG_DATA = 3'b010,
    STG_DEVR = 3'b011,
    STG_RDAT = 3'b100
  } stage_t;

endpackage

/* File: src/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // pin and filtered level
  input  wire logic pinIn,
  output logic      level
);

  logic s1_r, s2_r, s3_r, level_r, level_nxt;

  // ****************************************
  // three stages, accept when last two agree
  // ****************************************
  always_comb begin
    level_nxt = (s2_r == s3_r) ? s3_r : level_r;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_r    <= 1'b1;
      s2_r    <= 1'b1;
      s3_r    <= 1'b1;
      level_r <= 1'b1;
    end else begin
      s1_r    <= pinIn;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      level_r <= level_nxt;
    end
  end

  assign level = level_r;

endmodule

/* File: src/quarter_tick.sv */
`timescale 1ns/1ps
module quarter_tick (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // control
  input  wire logic run,
  output logic      tick
);
  import eeprom_engine_pkg::*;

  localparam logic [7:0] LAST = 8'(QUARTER_CYC - 1);

  logic [7:0] cnt_r, cnt_nxt;
  logic       tick_r, tick_nxt;

  // ****************************************
  // one pulse per quarter bit while running
  // ****************************************
  always_comb begin
    cnt_nxt  = 8'h00;
    tick_nxt = 1'b0;
    if (run) begin
      tick_nxt = (cnt_r == LAST);
      cnt_nxt  = (cnt_r == LAST) ? 8'h00 : cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r  <= 8'h00;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule

/* File: src/serial_eeprom_command_engine.sv */
// Contract
// RULE1: command bits 30:24 hold target address, default 1010000, sent when addressing
// RULE2: command bits 23:16 are sent as the word address
// RULE3: command bits 15:8 are written on a write, ignored on a read
// RULE4: command bit 1 picks four-byte or one-byte read; no effect on writes
// RULE5: writing command byte 0 launches; bit 0 set means read
// RULE6: narrow hosts write the upper command bytes before the launching byte
// RULE7: fetched bytes land in the read-data register
// RULE8: first byte in bits 7:0, following bytes in ascending higher bytes
// RULE9: status bits 7,6,5 flag no-ack of device, word, second address
// RULE10: a clean transfer leaves the three acknowledge bits at zero
// RULE11: status bit 0 is one when finished, zero while running
// RULE12: launch clears done and ack bits; run write or read; done after stop
// RULE13: address no-ack records its bit, sends stop and reports done
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module serial_eeprom_command_engine (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [3:0]  pstrb,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // two-wire bus, open drain
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOeN,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOeN,
  // interrupt
  output logic             irq
);
  import eeprom_engine_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  command_t    cmd_r, cmd_nxt;
  logic [1:0]  intStat_r, intStat_nxt, intMask_r, intMask_nxt, intSet;
  logic        irq_r, irq_nxt;
  eng_state_t  state_r, state_nxt;
  stage_t      stage_r, stage_nxt;
  logic [1:0]  q_r, q_nxt, byteCnt_r, byteCnt_nxt;
  logic [3:0]  bitCnt_r, bitCnt_nxt;
  logic [7:0]  shift_r, shift_nxt;
  logic [2:0]  ack_r, ack_nxt;
  logic        done_r, done_nxt, sampled_r, sampled_nxt;
  logic [31:0] rdData_r, rdData_nxt;
  logic        sclOeN_r, sclOeN_nxt, sdaOeN_r, sdaOeN_nxt;
  logic        sclOut_r, sdaOut_r;
  logic        sclHigh, sdaHigh, tick, step, access, wrAcc, launch, lastByte;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] tx_byte(input stage_t stg, input command_t c);
    tx_byte = {c.devAddr, 1'b0};
    unique case (stg)
      STG_DEVW: tx_byte = {c.devAddr, 1'b0};
      STG_MEM:  tx_byte = c.memAddr;
      STG_DATA: tx_byte = c.wrData;
      STG_DEVR: tx_byte = {c.devAddr, 1'b1};
      STG_RDAT: tx_byte = 8'h00;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      old[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
    merge = old;
  endfunction

  // ****************************************
  // pins and bit timing
  // ****************************************
  pin_sync u_scl_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pinIn   (sclIn),
    .level   (sclHigh)
  );

  pin_sync u_sda_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pinIn   (sdaIn),
    .level   (sdaHigh)
  );

  quarter_tick u_tick (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (state_r != ST_IDLE),
    .tick    (tick)
  );

  // a slave stretching the clock holds us in the high quarter
  assign step = tick && !(q_r == 2'h2 && !sclHigh);

  // ****************************************
  // apb slave and registers
  // ****************************************
  assign access = psel && penable && pready_r;
  assign wrAcc  = access && pwrite;
  assign launch = wrAcc && paddr == OFS_COMMAND && pstrb[0] && state_r == ST_IDLE; // [RULE5]

  always_comb begin
    pready_nxt  = psel && !penable;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    cmd_nxt     = cmd_r;
    intMask_nxt = intMask_r;
    intStat_nxt = intStat_r;
    if (psel && !penable) begin
      prdata_nxt = 32'h0000_0000;
      unique case (paddr)
        OFS_COMMAND:  prdata_nxt = 32'h0000_0000;
        OFS_RDDATA:   prdata_nxt = rdData_r; // [RULE7]
        OFS_STATUS: begin
          prdata_nxt[ACK_LSB +: 3] = ack_r; // [RULE9]
          prdata_nxt[DONE_BIT]     = done_r; // [RULE11]
        end
        OFS_INT_STAT: prdata_nxt[1:0] = intStat_r;
        OFS_INT_MASK: prdata_nxt[1:0] = intMask_r;
        default:      pslverr_nxt = 1'b1;
      endcase
    end
    // upper bytes may arrive in earlier narrow writes
    if (wrAcc && paddr == OFS_COMMAND && state_r == ST_IDLE) begin
      cmd_nxt = command_t'(merge(cmd_r, pwdata, pstrb)); // [RULE6]
    end
    if (wrAcc && paddr == OFS_INT_MASK && pstrb[0]) begin
      intMask_nxt = pwdata[1:0];
    end
    if (wrAcc && paddr == OFS_INT_STAT && pstrb[0]) begin
      intStat_nxt = intStat_r & ~pwdata[1:0];
    end
    intStat_nxt = intStat_nxt | intSet;
    irq_nxt     = |(intStat_r & intMask_r);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      cmd_r     <= CMD_RESET; // [RULE1]
      intMask_r <= 2'h0;
      intStat_r <= 2'h0;
      irq_r     <= 1'b0;
    end else begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      cmd_r     <= cmd_nxt;
      intMask_r <= intMask_nxt;
      intStat_r <= intStat_nxt;
      irq_r     <= irq_nxt;
    end
  end

  // ****************************************
  // transfer engine
  // ****************************************
  assign lastByte = !cmd_r.rdLen4 || byteCnt_r == LAST_SEQ; // [RULE4]

  always_comb begin
    state_nxt   = state_r;
    stage_nxt   = stage_r;
    q_nxt       = q_r;
    bitCnt_nxt  = bitCnt_r;
    byteCnt_nxt = byteCnt_r;
    shift_nxt   = shift_r;
    ack_nxt     = ack_r;
    done_nxt    = done_r;
    sampled_nxt = sampled_r;
    rdData_nxt  = rdData_r;
    sclOeN_nxt  = sclOeN_r;
    sdaOeN_nxt  = sdaOeN_r;
    intSet      = 2'h0;
    if (state_r == ST_IDLE) begin
      sclOeN_nxt = 1'b1;
      sdaOeN_nxt = 1'b1;
      if (launch) begin
        done_nxt    = 1'b0; // [RULE12]
        ack_nxt     = 3'h0; // [RULE10] [RULE12]
        stage_nxt   = STG_DEVW;
        q_nxt       = 2'h0;
        byteCnt_nxt = 2'h0;
        state_nxt   = ST_START;
      end
    end else if (step) begin
      q_nxt = q_r + 2'h1;
      unique case (state_r)
        ST_START: begin
          unique case (q_r)
            2'h0: begin
              sdaOeN_nxt = 1'b1;
              sclOeN_nxt = 1'b1;
            end
            2'h1: sdaOeN_nxt = 1'b1;
            2'h2: sdaOeN_nxt = 1'b0;
            2'h3: begin
              sclOeN_nxt = 1'b0;
              bitCnt_nxt = 4'h0;
              shift_nxt  = tx_byte(stage_r, cmd_r); // [RULE1] [RULE2] [RULE3]
              state_nxt  = ST_TX;
            end
          endcase
        end
        ST_TX: begin
          unique case (q_r)
            2'h0: sdaOeN_nxt = (bitCnt_r == 4'h8) ? 1'b1 : shift_r[7];
            2'h1: sclOeN_nxt = 1'b1;
            2'h2: sampled_nxt = sdaHigh;
            2'h3: begin
              sclOeN_nxt = 1'b0;
              if (bitCnt_r != 4'h8) begin
                shift_nxt  = {shift_r[6:0], 1'b0};
                bitCnt_nxt = bitCnt_r + 4'h1;
              end else if (sampled_r) begin
                // no acknowledge: flag it and close with a stop
                unique case (stage_r)
                  STG_DEVW: ack_nxt[ACK_DEV] = 1'b1; // [RULE9] [RULE13]
                  STG_MEM:  ack_nxt[ACK_MEM] = 1'b1; // [RULE9] [RULE13]
                  default:  ack_nxt[ACK_SECOND] = 1'b1; // [RULE9] [RULE13]
                endcase
                intSet[EV_NACK] = 1'b1;
                state_nxt       = ST_STOP;
              end else begin
                bitCnt_nxt = 4'h0;
                unique case (stage_r)
                  STG_DEVW: begin
                    stage_nxt = STG_MEM;
                    shift_nxt = tx_byte(STG_MEM, cmd_r); // [RULE2]
                  end
                  STG_MEM: begin
                    if (cmd_r.isRead) begin
                      stage_nxt = STG_DEVR;
                      state_nxt = ST_START;
                    end else begin
                      stage_nxt = STG_DATA;
                      shift_nxt = tx_byte(STG_DATA, cmd_r); // [RULE3]
                    end
                  end
                  STG_DEVR: begin
                    stage_nxt = STG_RDAT;
                    state_nxt = ST_RX;
                  end
                  default: state_nxt = ST_STOP;
                endcase
              end
            end
          endcase
        end
        ST_RX: begin
          unique case (q_r)
            2'h0: sdaOeN_nxt = (bitCnt_r == 4'h8) ? lastByte : 1'b1;
            2'h1: sclOeN_nxt = 1'b1;
            2'h2: if (bitCnt_r != 4'h8) shift_nxt = {shift_r[6:0], sdaHigh};
            2'h3: begin
              sclOeN_nxt = 1'b0;
              if (bitCnt_r == 4'h7) begin
                rdData_nxt[8*byteCnt_r +: 8] = shift_r; // [RULE7] [RULE8]
              end
              if (bitCnt_r != 4'h8) begin
                bitCnt_nxt = bitCnt_r + 4'h1;
              end else if (lastByte) begin
                state_nxt = ST_STOP; // [RULE4]
              end else begin
                bitCnt_nxt  = 4'h0;
                byteCnt_nxt = byteCnt_r + 2'h1; // [RULE8]
              end
            end
          endcase
        end
        ST_STOP: begin
          unique case (q_r)
            2'h0: sdaOeN_nxt = 1'b0;
            2'h1: sclOeN_nxt = 1'b1;
            2'h2: sdaOeN_nxt = 1'b1;
            2'h3: begin
              done_nxt        = 1'b1; // [RULE11] [RULE12] [RULE13]
              intSet[EV_DONE] = 1'b1;
              state_nxt       = ST_IDLE;
            end
          endcase
        end
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r   <= ST_IDLE;
      stage_r   <= STG_DEVW;
      q_r       <= 2'h0;
      bitCnt_r  <= 4'h0;
      byteCnt_r <= 2'h0;
      shift_r   <= 8'h00;
      ack_r     <= 3'h0;
      done_r    <= 1'b0;
      sampled_r <= 1'b1;
      rdData_r  <= RDATA_RESET;
      sclOeN_r  <= 1'b1;
      sdaOeN_r  <= 1'b1;
      sclOut_r  <= 1'b0;
      sdaOut_r  <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      stage_r   <= stage_nxt;
      q_r       <= q_nxt;
      bitCnt_r  <= bitCnt_nxt;
      byteCnt_r <= byteCnt_nxt;
      shift_r   <= shift_nxt;
      ack_r     <= ack_nxt;
      done_r    <= done_nxt;
      sampled_r <= sampled_nxt;
      rdData_r  <= rdData_nxt;
      sclOeN_r  <= sclOeN_nxt;
      sdaOeN_r  <= sdaOeN_nxt;
      sclOut_r  <= 1'b0;
      sdaOut_r  <= 1'b0;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign sclOut  = sclOut_r;
  assign sclOeN  = sclOeN_r;
  assign sdaOut  = sdaOut_r;
  assign sdaOeN  = sdaOeN_r;
  assign irq     = irq_r;

  // ****************************************
  // assertions
  // ****************************************
  property p_launch_clears;
    @(posedge clk) disable iff (sys_rst)
    launch |=> (!done_r && ack_r == 3'h0 && state_r == ST_START);
  endproperty
  a_launch_clears: assert property (p_launch_clears) else $error("launch did not clear"); // [RULE12]

  property p_busy_not_done;
    @(posedge clk) disable iff (sys_rst)
    (state_r != ST_IDLE) |-> !done_r;
  endproperty
  a_busy_not_done: assert property (p_busy_not_done) else $error("done while busy"); // [RULE11]

  property p_no_launch_upper;
    @(posedge clk) disable iff (sys_rst)
    (wrAcc && paddr == OFS_COMMAND && !pstrb[0] && state_r == ST_IDLE) |=> state_r == ST_IDLE;
  endproperty
  a_no_launch_upper: assert property (p_no_launch_upper) else $error("launch w/o byte 0"); // [RULE5]

  property p_dev_bits;
    @(posedge clk) disable iff (sys_rst)
    (state_r == ST_TX && stage_r == STG_DEVW && q_r == 2'h1 && bitCnt_r < 4'h7)
      |-> sdaOeN_r == cmd_r.devAddr[3'h6 - bitCnt_r[2:0]];
  endproperty
  a_dev_bits: assert property (p_dev_bits) else $error("device address bit wrong"); // [RULE1]

  property p_mem_bits;
    @(posedge clk) disable iff (sys_rst)
    (state_r == ST_TX && stage_r == STG_MEM && q_r == 2'h1 && bitCnt_r < 4'h8)
      |-> sdaOeN_r == cmd_r.memAddr[3'h7 - bitCnt_r[2:0]];
  endproperty
  a_mem_bits: assert property (p_mem_bits) else $error("word address bit wrong"); // [RULE2]

  property p_wr_bits;
    @(posedge clk) disable iff (sys_rst)
    (state_r == ST_TX && stage_r == STG_DATA && q_r == 2'h1 && bitCnt_r < 4'h8)
      |-> (!cmd_r.isRead && sdaOeN_r == cmd_r.wrData[3'h7 - bitCnt_r[2:0]]);
  endproperty
  a_wr_bits: assert property (p_wr_bits) else $error("write data bit wrong"); // [RULE3]

  property p_rx_only_read;
    @(posedge clk) disable iff (sys_rst)
    (state_r == ST_RX) |-> (cmd_r.isRead && (cmd_r.rdLen4 || byteCnt_r == 2'h0));
  endproperty
  a_rx_only_read: assert property (p_rx_only_read) else $error("bad receive phase"); // [RULE4]

  property p_nack_stop;
    @(posedge clk) disable iff (sys_rst)
    (step && state_r == ST_TX && q_r == 2'h3 && bitCnt_r == 4'h8 && sampled_r)
      |=> (state_r == ST_STOP && ack_r != 3'h0) ##[1:700] done_r;
  endproperty
  a_nack_stop: assert property (p_nack_stop) else $error("no-ack not closed"); // [RULE13]

  property p_byte0_stored;
    @(posedge clk) disable iff (sys_rst)
    (step && state_r == ST_RX && q_r == 2'h3 && bitCnt_r == 4'h7 && byteCnt_r == 2'h0)
      |=> rdData_r[7:0] == $past(shift_r);
  endproperty
  a_byte0_stored: assert property (p_byte0_stored) else $error("read byte lost"); // [RULE8]

  property p_irq;
    @(posedge clk) disable iff (sys_rst)
    ##1 irq_r == |($past(intStat_r) & $past(intMask_r));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");

  c_write_done: cover property (@(posedge clk) disable iff (sys_rst)
    !cmd_r.isRead && $rose(done_r) && ack_r == 3'h0);
  c_read4_done: cover property (@(posedge clk) disable iff (sys_rst)
    cmd_r.isRead && cmd_r.rdLen4 && $rose(done_r) && ack_r == 3'h0);
  c_dev_nack: cover property (@(posedge clk) disable iff (sys_rst)
    $rose(done_r) && ack_r[ACK_DEV]);

endmodule

/* File: dv/eeprom_model.sv */
`timescale 1ns/1ps
module eeprom_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  // two-wire bus levels
  input  wire logic scl,
  input  wire logic sda,
  // data pull, low while pulling
  output logic      sdaOeN
);
  logic [7:0] mem [256];
  logic [7:0] sh;
  logic [7:0] ptr;
  logic       mack;
  int         bc;
  int         ph;
  bit         sel;
  bit         rd;
  bit         goRd;

  initial begin
    sdaOeN = 1'b1;
    ph = 3;
  end

  // start or repeated start restarts addressing
  always @(negedge sda) if (scl) begin
    // the clock fall that closes the start is not a data bit
    bc = -1;
    ph = 0;
    rd = 0;
    sdaOeN = 1'b1;
  end

  // stop ends the access
  always @(posedge sda) if (scl) begin
    bc = 0;
    ph = 3;
    rd = 0;
  end

  always @(posedge scl) begin
    if (!rd) sh = {sh[6:0], sda};
    else if (bc == 8) mack = sda;
  end

  // released data line floats to the pull-up level
  always @(negedge scl) begin
    bc = bc + 1;
    if (bc == 8 && !rd && ph < 3) begin
      case (ph)
        0: begin
          sel = (sh[7:1] == DEV_ADDR);
          goRd = sh[0] && sel;
        end
        1: ptr = sh;
        default: begin
          mem[ptr] = sh;
          ptr = ptr + 8'h01;
        end
      endcase
      if (sel) sdaOeN = 1'b0;
      ph = !sel ? 3 : (ph < 2 ? ph + 1 : ph);
    end else if (bc == 8 && rd) begin
      sdaOeN = 1'b1;
    end else if (bc == 9) begin
      bc = 0;
      sdaOeN = 1'b1;
      if (goRd || (rd && !mack)) begin
        rd = 1;
        goRd = 0;
        sh = mem[ptr];
        ptr = ptr + 8'h01;
        sdaOeN = sh[7];
      end else if (rd) begin
        rd = 0;
        ph = 3;
      end
    end else if (rd) begin
      sdaOeN = sh[7-bc];
    end
  end
endmodule

/* File: dv/serial_eeprom_command_engine_tb_top.sv */
`timescale 1ns/1ps
module serial_eeprom_command_engine_tb_top;
  import eeprom_engine_pkg::*;
  logic        clk;
  logic        sys_rst;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [3:0]  pstrb;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sclOut;
  logic        sclOeN;
  logic        sdaOut;
  logic        sdaOeN;
  logic        irq;
  logic        eepOeN;
  logic        sclW;
  logic        sdaW;
  logic [31:0] seed;
  logic [31:0] r;
  logic [31:0] x;
  logic [7:0]  a;
  logic [7:0]  d;
  logic        e;
  int          refMem [256];
  int          b;
  int          n_mismatch;
  int          compares;

  // ****************************************
  // wires with pull-ups
  // ****************************************
  assign sclW = sclOeN ? 1'b1 : sclOut;
  assign sdaW = (sdaOeN ? 1'b1 : sdaOut) & eepOeN;

  serial_eeprom_command_engine dut (
    .clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pstrb(pstrb), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclIn(sclW), .sclOut(sclOut), .sclOeN(sclOeN), .sdaIn(sdaW),
    .sdaOut(sdaOut), .sdaOeN(sdaOeN), .irq(irq)
  );

  eeprom_model eep (.scl(sclW), .sda(sdaW), .sdaOeN(eepOeN));

  always #10 clk = ~clk;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd,
                     input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic waitDone(input logic [31:0] exp);
    apb(0, OFS_STATUS, 32'h0, 4'h0);
    chk("busy", r, 32'h0);
    while (r[0] !== 1'b1) begin
      apb(0, OFS_STATUS, 32'h0, 4'h0);
    end
    chk("status", r, exp);
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pstrb = 4'h0;
    pwdata = 32'h0;
    seed = 32'h0001_4F97;
    for (int i = 0; i < 256; i++) begin
      x = xs();
      refMem[i] = int'(x[7:0]);
      eep.mem[i] = x[7:0];
    end
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    apb(0, OFS_STATUS, 32'h0, 4'h0);
    chk("status reset", r, 32'h0);
    apb(0, OFS_COMMAND, 32'h0, 4'h0);
    chk("command reads zero", r, 32'h0);
    apb(0, 12'h4C0, 32'h0, 4'h0);
    chk("unmapped error", {31'h0, e}, 32'h1);
    apb(1, OFS_INT_MASK, 32'h3, 4'hF);
    // write at default device address, upper bytes first, length bit set
    x = xs();
    a = x[23:16];
    d = x[15:8];
    apb(1, OFS_COMMAND, {8'h00, a, d, 8'h00}, 4'h6);
    apb(1, OFS_COMMAND, 32'h2, 4'h1);
    waitDone(32'h1);
    refMem[a] = int'(d);
    chk("byte written", eep.mem[a], refMem[a]);
    chk("next byte kept", eep.mem[a+8'h01], refMem[a+8'h01]);
    chk("irq done", irq, 1'b1);
    apb(0, OFS_INT_STAT, 32'h0, 4'h0);
    chk("event done", r, 32'h1);
    apb(1, OFS_INT_STAT, 32'h1, 4'hF);
    repeat (2) @(posedge clk);
    chk("irq cleared", irq, 1'b0);
    // single read with noise in the write-data field
    apb(1, OFS_COMMAND, {8'h50, a, ~d, 8'h01}, 4'hF);
    waitDone(32'h1);
    apb(0, OFS_RDDATA, 32'h0, 4'h0);
    chk("single byte", r[7:0], refMem[a]);
    // four-byte sequential read
    x = xs();
    b = int'(x[7:0]);
    apb(1, OFS_COMMAND, {8'h50, x[7:0], 8'h00, 8'h03}, 4'hF);
    waitDone(32'h1);
    for (int k = 0; k < 4; k++) x[8*k +: 8] = 8'(refMem[(b+k)%256]);
    apb(0, OFS_RDDATA, 32'h0, 4'h0);
    chk("four bytes", r, x);
    // absent device address, interrupt masked then enabled
    apb(1, OFS_INT_STAT, 32'h3, 4'hF);
    apb(1, OFS_INT_MASK, 32'h0, 4'hF);
    apb(1, OFS_COMMAND, 32'h5100_0000, 4'hF);
    waitDone(32'h81);
    chk("irq masked", irq, 1'b0);
    apb(0, OFS_INT_STAT, 32'h0, 4'h0);
    chk("event nack", r, 32'h3);
    apb(1, OFS_INT_MASK, 32'h2, 4'hF);
    repeat (2) @(posedge clk);
    chk("irq nack", irq, 1'b1);
    apb(1, OFS_INT_STAT, 32'h2, 4'hF);
    repeat (2) @(posedge clk);
    chk("irq nack cleared", irq, 1'b0);
    end_sim();
  end
endmodule
